// ---- hw/abs_transfer_supervisor.sv ----
// Amplifier-side supervisor of the absolute position transfer and its shared pins.
// Assumes all pin inputs synchronous to pclk and an APB master on the register side;
// the controller paces the handshake and keeps its own timing and retry policy.
`timescale 1ns/1ps
`include "ats_map.svh"

module abs_transfer_supervisor
(
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [`ATS_ADDR_W-1:0]   paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic                     servo_on_in,
	input  wire logic                     transfer_mode_in,
	input  wire logic                     transfer_request_in,
	input  wire logic                     alarm_reset_in,
	input  wire logic                     emg_stop_in,
	input  wire logic                     alarm_in,
	input  wire logic                     home_mode_in,
	input  wire logic                     home_start_in,
	input  wire ats_pkg::ats_word_t       motor_position_in,
	input  wire logic                     in_position_in,
	input  wire logic                     zero_speed_in,
	input  wire logic                     torque_limiting_in,
	output logic                          ready_or_torque_limit_in,
	output logic                          data_bit0_out,
	output logic                          data_bit1_out,
	output logic                          brake_interlock_out,
	output logic                          irq
);
	logic [`ATS_LVL_W-1:0]   lvl;
	logic [`ATS_LVL_W-1:0]   rises;
	logic [`ATS_LVL_W-1:0]   falls;
	logic [1:0]              sh_bits;
	logic                    sh_last;
	logic                    sh_load;
	logic                    sh_step;
	logic                    link_ok;

	ats_pkg::ats_state_t     state_r;
	ats_pkg::ats_state_t     state_nxt;
	logic                    pending_r;
	logic                    pending_nxt;
	ats_pkg::ats_word_t      home_ofs_r;
	ats_pkg::ats_word_t      home_ofs_nxt;
	ats_pkg::ats_word_t      rel_pos;
	logic [`ATS_EVT_W-1:0]   evt;

	logic [`ATS_PARAM_W-1:0] param_r;
	logic [`ATS_PARAM_W-1:0] param_nxt;
	logic [`ATS_EVT_W-1:0]   stat_r;
	logic [`ATS_EVT_W-1:0]   stat_nxt;
	logic [`ATS_EVT_W-1:0]   mask_r;
	logic [`ATS_EVT_W-1:0]   mask_nxt;
	logic [31:0]             prdata_r;
	logic [31:0]             prdata_nxt;
	logic                    pready_r;
	logic                    pready_nxt;
	logic                    pslverr_r;
	logic                    pslverr_nxt;
	logic                    bus_wr;
	logic                    irq_r;
	logic                    irq_nxt;

	logic                    pin_rdy_r;
	logic                    pin_rdy_nxt;
	logic [1:0]              pin_bits_r;
	logic [1:0]              pin_bits_nxt;
	logic                    brake_r;
	logic                    brake_nxt;

	// Edge sources for triggers, home start and handshake
	assign lvl = {transfer_mode_in, home_start_in, emg_stop_in, alarm_reset_in, servo_on_in};

	ats_edge_det u_edges
	(
		.pclk     (pclk),
		.presetn  (presetn),
		.level_in (lvl),
		.rise     (rises),
		.fall     (falls)
	);

	ats_shift_out u_shift
	(
		.pclk     (pclk),
		.presetn  (presetn),
		.load     (sh_load),
		.step     (sh_step),
		.word_in  (rel_pos),
		.bits     (sh_bits),
		.last     (sh_last)
	);

	// Position as seen from the home point
	assign rel_pos = motor_position_in - home_ofs_r;
	// A transfer only runs while servo is on and no stop condition stands
	assign link_ok = servo_on_in & ~alarm_in & ~emg_stop_in;

	// Handshake sequencer; the controller paces every step
	always_comb
	begin
		state_nxt = state_r;
		sh_load   = 1'b0;
		sh_step   = 1'b0;
		evt       = '0;
		unique case (state_r)
			ats_pkg::ATS_IDLE:
			begin
				if (transfer_mode_in && link_ok) // RQ8
				begin
					sh_load   = 1'b1;
					state_nxt = ats_pkg::ATS_WAIT_REQ;
				end
			end
			ats_pkg::ATS_WAIT_REQ:
			begin
				if (transfer_request_in)
				begin
					sh_step   = 1'b1;
					state_nxt = ats_pkg::ATS_SEND;
				end
			end
			ats_pkg::ATS_SEND:
			begin
				if (!transfer_request_in)
					state_nxt = sh_last ? ats_pkg::ATS_DONE : ats_pkg::ATS_WAIT_REQ;
			end
			ats_pkg::ATS_DONE:
			begin
				if (!transfer_mode_in)
				begin
					evt[`ATS_EVT_DONE] = 1'b1;
					state_nxt          = ats_pkg::ATS_IDLE;
				end
			end
		endcase
		// Dropping the mode or losing servo mid-transfer abandons it
		if (state_r != ats_pkg::ATS_IDLE && state_r != ats_pkg::ATS_DONE && (!transfer_mode_in || !link_ok))
		begin
			evt[`ATS_EVT_ABORT] = 1'b1;
			sh_step             = 1'b0;
			state_nxt           = ats_pkg::ATS_IDLE;
		end
		// Power-up, servo-on, alarm reset and emergency release each call for a transfer
		evt[`ATS_EVT_TRIG] = rises[`ATS_LVL_SERVO] | rises[`ATS_LVL_ALM_RST] | falls[`ATS_LVL_EMG]; // RQ8 RQ9
		// Home set only outside a transfer, so the word sent never jumps mid-way
		evt[`ATS_EVT_HOME] = home_mode_in & rises[`ATS_LVL_HOME] & (state_r == ats_pkg::ATS_IDLE); // RQ3
	end

	// Pending flag: a new trigger wins over the completion that clears it
	always_comb
	begin
		pending_nxt  = pending_r;
		home_ofs_nxt = home_ofs_r;
		if (evt[`ATS_EVT_DONE])
			pending_nxt = 1'b0;
		if (evt[`ATS_EVT_TRIG])
			pending_nxt = 1'b1; // RQ9
		if (evt[`ATS_EVT_HOME])
			home_ofs_nxt = motor_position_in; // RQ3
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r    <= ats_pkg::ATS_IDLE;
			pending_r  <= 1'b1; // RQ8
			home_ofs_r <= '0;
		end
		else
		begin
			state_r    <= state_nxt;
			pending_r  <= pending_nxt;
			home_ofs_r <= home_ofs_nxt;
		end
	end

	// Shared pins take their meaning from the transfer mode input
	always_comb
	begin
		brake_nxt = (param_r == `ATS_BRAKE_SEL) & link_ok; // RQ6
		if (transfer_mode_in)
		begin
			pin_rdy_nxt  = (state_nxt == ats_pkg::ATS_WAIT_REQ) | (state_nxt == ats_pkg::ATS_DONE); // RQ15
			pin_bits_nxt = sh_bits; // RQ16
		end
		else
		begin
			pin_rdy_nxt  = torque_limiting_in; // RQ15
			pin_bits_nxt = {zero_speed_in, in_position_in}; // RQ16
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_rdy_r  <= 1'b0;
			pin_bits_r <= 2'h0;
			brake_r    <= 1'b0;
		end
		else
		begin
			pin_rdy_r  <= pin_rdy_nxt;
			pin_bits_r <= pin_bits_nxt;
			brake_r    <= brake_nxt;
		end
	end

	// APB slave: answer registered in the setup cycle, no wait states;
	// writes land only at the access edge, where the master sees pready
	assign bus_wr = psel & penable & pready_r & pwrite;

	always_comb
	begin
		param_nxt   = param_r;
		mask_nxt    = mask_r;
		prdata_nxt  = prdata_r;
		pready_nxt  = psel & ~penable;
		pslverr_nxt = 1'b0;
		stat_nxt    = stat_r;
		if (bus_wr && paddr == `ATS_INT_STAT_OFS)
			stat_nxt = stat_r & ~pwdata[`ATS_EVT_W-1:0];
		if (bus_wr && paddr == `ATS_CTRL_OFS)
			param_nxt = pwdata[`ATS_PARAM_W-1:0];
		if (bus_wr && paddr == `ATS_INT_MASK_OFS)
			mask_nxt = pwdata[`ATS_EVT_W-1:0];
		stat_nxt = stat_nxt | evt; // Set wins over the write-one clear
		if (psel && !penable)
		begin
			prdata_nxt = 32'h0000_0000;
			unique case (paddr)
				`ATS_CTRL_OFS:
					prdata_nxt[`ATS_PARAM_W-1:0] = param_r;
				`ATS_STATUS_OFS:
					prdata_nxt[5:0] = {brake_r, transfer_mode_in, pending_r, 1'b0, state_r};
				`ATS_INT_STAT_OFS:
					prdata_nxt[`ATS_EVT_W-1:0] = stat_r;
				`ATS_INT_MASK_OFS:
					prdata_nxt[`ATS_EVT_W-1:0] = mask_r;
				`ATS_POSITION_OFS:
					prdata_nxt = rel_pos;
				`ATS_HOME_OFS_OFS:
					prdata_nxt = home_ofs_r;
				default:
					pslverr_nxt = 1'b1; // Unmapped address
			endcase
			if (pwrite)
				prdata_nxt = 32'h0000_0000;
		end
		irq_nxt = |(stat_nxt & mask_nxt);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			param_r   <= `ATS_PARAM_RST;
			mask_r    <= `ATS_MASK_RST;
			stat_r    <= '0;
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			irq_r     <= 1'b0;
		end
		else
		begin
			param_r   <= param_nxt;
			mask_r    <= mask_nxt;
			stat_r    <= stat_nxt;
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			irq_r     <= irq_nxt;
		end
	end

	assign prdata                   = prdata_r;
	assign pready                   = pready_r;
	assign pslverr                  = pslverr_r;
	assign irq                      = irq_r;
	assign ready_or_torque_limit_in = pin_rdy_r;
	assign data_bit0_out            = pin_bits_r[0];
	assign data_bit1_out            = pin_bits_r[1];
	assign brake_interlock_out      = brake_r;

	// Checks on the pin behaviour and the triggers
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_pin_torque_mode: assert property (!transfer_mode_in |=> ready_or_torque_limit_in == $past(torque_limiting_in)) // RQ15
		else $error("shared pin does not show torque limit outside transfer");
	a_pin_ready_wait: assert property (transfer_mode_in && state_r == ats_pkg::ATS_WAIT_REQ
		&& !transfer_request_in && link_ok |=> ready_or_torque_limit_in) // RQ15
		else $error("shared pin not ready while waiting for request");
	a_bits_status: assert property (!transfer_mode_in |=>
		{data_bit1_out, data_bit0_out} == {$past(zero_speed_in), $past(in_position_in)}) // RQ16
		else $error("data pins do not show status outside transfer");
	a_brake_gate: assert property (param_r != `ATS_BRAKE_SEL |=> !brake_interlock_out) // RQ6
		else $error("brake interlock driven without selection");
	a_home_capture: assert property (home_mode_in && rises[`ATS_LVL_HOME] && state_r == ats_pkg::ATS_IDLE
		|=> home_ofs_r == $past(motor_position_in) ##1 home_ofs_r == $past(home_ofs_r)) // RQ3
		else $error("home offset not taken at home start");
	a_trigger_pend: assert property (rises[`ATS_LVL_SERVO] || rises[`ATS_LVL_ALM_RST] || falls[`ATS_LVL_EMG]
		|=> pending_r && stat_r[`ATS_EVT_TRIG]) // RQ8 RQ9
		else $error("transfer trigger lost");
	a_start_load: assert property (state_r == ats_pkg::ATS_IDLE && transfer_mode_in && link_ok
		|=> state_r == ats_pkg::ATS_WAIT_REQ) // RQ8
		else $error("transfer did not start on mode");

	c_transfer_done: cover property (state_r == ats_pkg::ATS_DONE ##1 state_r == ats_pkg::ATS_IDLE);
	c_home_set: cover property (evt[`ATS_EVT_HOME]);
	c_abort: cover property (evt[`ATS_EVT_ABORT]);
endmodule // abs_transfer_supervisor

// ---- hw/ats_map.svh ----
// Offsets, field positions, reset values and counts of the position transfer supervisor.
// Assumes byte addresses on an APB bus with 32-bit data, one aligned word per register.
//
// Overview of operation
// RQ1 - Controller pulses deviation clear only during home return
// RQ2 - Controller holds data-set clear pulse 100 ms
// RQ3 - Home return start in home mode sets home
// RQ4 - Controller keeps motor stopped during transfer
// RQ5 - Controller keeps torque limiting off during transfer
// RQ6 - Brake interlock output when parameter 3 selects it
// RQ7 - Controller derives torque status outside transfer only
// RQ8 - Transfer at power-up and controller restart
// RQ9 - Transfer again after alarm reset, emergency release
// RQ10 - Controller retries transfer up to three times
// RQ11 - Controller flags checksum error after last retry
// RQ12 - Controller times handshake, flags communication error
// RQ13 - Jog and dog home only after transfer
// RQ14 - Each axis uses its own separate resources
// RQ15 - Shared pin: ready in transfer, torque-limit otherwise
// RQ16 - Data pins: position bits, else completion/zero speed
// RQ17 - Controller holds handshake timeout limits as constants
`ifndef ATS_MAP_SVH
`define ATS_MAP_SVH

`define ATS_ADDR_W        8
`define ATS_CTRL_OFS      8'h00
`define ATS_STATUS_OFS    8'h04
`define ATS_INT_STAT_OFS  8'h08
`define ATS_INT_MASK_OFS  8'h0c
`define ATS_POSITION_OFS  8'h10
`define ATS_HOME_OFS_OFS  8'h14

`define ATS_PARAM_W       4
`define ATS_PARAM_RST     4'h0
`define ATS_BRAKE_SEL     4'h1
`define ATS_EVT_W         4
`define ATS_EVT_TRIG      0
`define ATS_EVT_DONE      1
`define ATS_EVT_ABORT     2
`define ATS_EVT_HOME      3
`define ATS_MASK_RST      4'h0

`define ATS_LVL_W         5
`define ATS_LVL_SERVO     0
`define ATS_LVL_ALM_RST   1
`define ATS_LVL_EMG       2
`define ATS_LVL_HOME      3
`define ATS_LVL_MODE      4

`define ATS_CNT_W         5
`define ATS_DATA_CHUNKS   5'd16
`define ATS_LAST_CHUNK    5'd18
`define ATS_SUM_W         6

`endif

// ---- hw/ats_pkg.sv ----
// Types shared by the position transfer supervisor modules.
// Assumes the constants of ats_map.svh alongside.
package ats_pkg;
	// Handshake states, Gray along idle, wait, send, done
	typedef enum logic [1:0]
	{
		ATS_IDLE     = 2'b00,
		ATS_WAIT_REQ = 2'b01,
		ATS_SEND     = 2'b11,
		ATS_DONE     = 2'b10
	} ats_state_t;

	typedef logic [31:0] ats_word_t;
endpackage

// ---- hw/ats_edge_det.sv ----
// Edge detector for the synchronous level inputs of the supervisor.
// Assumes inputs already synchronous to pclk; the previous value resets to low,
// so a level already high at reset release counts as a rising edge.
`timescale 1ns/1ps
`include "ats_map.svh"

module ats_edge_det
(
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic [`ATS_LVL_W-1:0]   level_in,
	output logic      [`ATS_LVL_W-1:0]   rise,
	output logic      [`ATS_LVL_W-1:0]   fall
);
	logic [`ATS_LVL_W-1:0] prev_r;
	logic [`ATS_LVL_W-1:0] prev_nxt;

	// Next value is the present level
	always_comb
	begin
		prev_nxt = level_in;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prev_r <= '0;
		else
			prev_r <= prev_nxt;
	end

	// Edges compare present level to last cycle
	assign rise = level_in & ~prev_r;
	assign fall = ~level_in & prev_r;
endmodule // ats_edge_det

// ---- hw/ats_shift_out.sv ----
// Serialiser of a 32-bit position word and its 6-bit checksum, two bits per step.
// Assumes load and step never come together; steps are counted here and last flags the end.
`timescale 1ns/1ps
`include "ats_map.svh"

module ats_shift_out
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  load,
	input  wire logic                  step,
	input  wire ats_pkg::ats_word_t    word_in,
	output logic      [1:0]            bits,
	output logic                       last
);
	ats_pkg::ats_word_t          data_r;
	ats_pkg::ats_word_t          data_nxt;
	logic [`ATS_SUM_W-1:0]       sum_r;
	logic [`ATS_SUM_W-1:0]       sum_nxt;
	logic [`ATS_CNT_W-1:0]       cnt_r;
	logic [`ATS_CNT_W-1:0]       cnt_nxt;
	logic [1:0]                  bits_r;
	logic [1:0]                  bits_nxt;

	// Sum of the sixteen two-bit chunks, kept to six bits
	function automatic logic [`ATS_SUM_W-1:0] chunk_sum(input ats_pkg::ats_word_t w);
		logic [`ATS_SUM_W-1:0] s;
		s = '0;
		for (int i = 0; i < `ATS_DATA_CHUNKS; i++)
			s = s + {4'h0, w[2*i +: 2]};
		return s;
	endfunction

	// Data chunks go first, low bits first, then the checksum
	always_comb
	begin
		data_nxt = data_r;
		sum_nxt  = sum_r;
		cnt_nxt  = cnt_r;
		bits_nxt = bits_r;
		if (load)
		begin
			data_nxt = word_in;
			sum_nxt  = chunk_sum(word_in);
			cnt_nxt  = '0;
			bits_nxt = 2'h0;
		end
		else if (step)
		begin
			if (cnt_r < `ATS_DATA_CHUNKS)
			begin
				bits_nxt = data_r[1:0];
				data_nxt = {2'h0, data_r[31:2]};
			end
			else
			begin
				bits_nxt = sum_r[1:0];
				sum_nxt  = {2'h0, sum_r[`ATS_SUM_W-1:2]};
			end
			cnt_nxt = cnt_r + 5'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			data_r <= '0;
			sum_r  <= '0;
			cnt_r  <= '0;
			bits_r <= 2'h0;
		end
		else
		begin
			data_r <= data_nxt;
			sum_r  <= sum_nxt;
			cnt_r  <= cnt_nxt;
			bits_r <= bits_nxt;
		end
	end

	assign bits = bits_r;
	assign last = (cnt_r > `ATS_LAST_CHUNK); // All nineteen chunks are out
endmodule // ats_shift_out

// ---- verification/ats_ctrl_model.sv ----
// Behavioural controller that runs the position transfer handshake.
// Assumes the supervisor's pin timing; go is a one-cycle start pulse.
`timescale 1ns/1ps

module ats_ctrl_model
#(
	parameter int TMO     = 64, // Handshake limit in cycles
	parameter int RETRIES   = 3,
	parameter int CLEAR_MS  = 100, // Clear pulse length
	parameter int MS_CYCLES = 8    // Scan time scaled down so the pulse fits the bench
)
(
	input  wire logic        pclk,
	input  wire logic        go,
	input  wire logic        corrupt,
	input  wire logic        ready_in,
	input  wire logic        bit0_in,
	input  wire logic        bit1_in,
	input  wire logic        home_mode_in,
	input  wire logic        home_start_in,
	output logic             mode_out = 1'b0,
	output logic             request_out = 1'b0,
	output logic             torque_status,
	output logic [31:0]      word_out = 32'h0,
	output logic             sum_ok = 1'b0,
	output logic             xfer_done = 1'b0,
	output logic             comm_error_flag = 1'b0,
	output logic             checksum_error_flag = 1'b0,
	output logic             deviation_clear_out,
	output logic             motion_ok = 1'b0
);
	logic        bad, ok;
	logic [31:0] w;
	logic [5:0]  acc, rs;
	int          tries, n;
	logic        home_q = 1'b0, data_set_home_request = 1'b0, clear_pulse_request;
	int          clear_pulse_timer = 0;

	// Torque status only outside a transfer
	assign torque_status = ready_in & ~mode_out;

	// Clear pulse only for data-set home return, one shot per start press
	assign clear_pulse_request = home_mode_in & home_start_in & ~home_q;
	assign deviation_clear_out = data_set_home_request;

	always @(posedge pclk)
	begin
		home_q <= home_start_in;
		if (clear_pulse_request)
		begin
			data_set_home_request <= 1'b1;
			clear_pulse_timer <= 0;
		end
		else if (data_set_home_request)
		begin
			clear_pulse_timer <= clear_pulse_timer + 1;
			if (clear_pulse_timer == CLEAR_MS * MS_CYCLES - 1)
				data_set_home_request <= 1'b0;
		end
	end

	// Bounded wait; a stuck handshake is a communication fault
	task automatic wait_rdy(input logic lvl);
		int t;
		t = 0;
		while (ready_in !== lvl && t < TMO)
		begin
			@(posedge pclk);
			t++;
		end
		if (t >= TMO)
		begin
			bad = 1'b1;
			comm_error_flag <= 1'b1;
		end
	endtask

	// Whole transfer repeated on a bad sum; corrupt models line noise
	always
	begin
		@(posedge pclk);
		if (go)
		begin
			tries = 0;
			motion_ok <= 1'b0;
			bad = 1'b0;
			ok = 1'b0;
			while (!ok && !bad && tries <= RETRIES)
			begin
				w = 32'h0;
				acc = 6'h0;
				rs = 6'h0;
				mode_out <= 1'b1;
				@(posedge pclk);
				wait_rdy(1'b1);
				for (n = 0; n < 19 && !bad; n++)
				begin
					request_out <= 1'b1;
					@(posedge pclk);
					wait_rdy(1'b0);
					request_out <= 1'b0;
					@(posedge pclk);
					wait_rdy(1'b1);
					if (n < 16)
					begin
						w[2*n +: 2] = {bit1_in, bit0_in ^ (corrupt && n == 0)};
						acc = acc + {4'h0, w[2*n +: 2]};
					end
					else
						rs[2*(n-16) +: 2] = {bit1_in, bit0_in};
				end
				mode_out <= 1'b0;
				request_out <= 1'b0;
				@(posedge pclk);
				ok = (acc == rs);
				tries++;
			end
			if (!ok && !bad)
				checksum_error_flag <= 1'b1;
			if (!bad)
			begin
				word_out <= w;
				sum_ok <= ok;
				motion_ok <= ok;
				xfer_done <= 1'b1;
				@(posedge pclk);
				xfer_done <= 1'b0;
			end
		end
	end
endmodule // ats_ctrl_model

// ---- verification/test_abs_transfer_supervisor.sv ----
// Self-checking bench of the transfer supervisor with a controller model.
// Assumes ats_map.svh on the include path and a single 100 MHz clock.
`timescale 1ns/1ps
`include "ats_map.svh"

module test_abs_transfer_supervisor;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, motor_position_in = 32'h0, prdata, v, pos, a0;
	logic        servo_on_in = 1'b1, alarm_reset_in = 1'b0, emg_stop_in = 1'b0, alarm_in = 1'b0;
	logic        home_mode_in = 1'b0, home_start_in = 1'b0, in_position_in = 1'b0, zero_speed_in = 1'b0;
	logic        torque_limiting_in = 1'b0, go = 1'b0, corrupt = 1'b0, mode_q = 1'b0;
	logic        pready, pslverr, rdy_pin, d0, d1, brake, irq, mode, req, torque_status;
	logic        sum_ok, xfer_done, comm_error_flag, checksum_error_flag, dev_clr, motion_ok;
	logic [31:0] word_out, attempts = 32'h0;
	logic [32:0] q_apb[$], q_x[$];
	int          failures = 0, checks_done = 0, cycles = 0, i, t;

	abs_transfer_supervisor u_dut
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.servo_on_in(servo_on_in), .transfer_mode_in(mode), .transfer_request_in(req),
		.alarm_reset_in(alarm_reset_in), .emg_stop_in(emg_stop_in), .alarm_in(alarm_in),
		.home_mode_in(home_mode_in), .home_start_in(home_start_in),
		.motor_position_in(motor_position_in), .in_position_in(in_position_in),
		.zero_speed_in(zero_speed_in), .torque_limiting_in(torque_limiting_in),
		.ready_or_torque_limit_in(rdy_pin), .data_bit0_out(d0), .data_bit1_out(d1),
		.brake_interlock_out(brake), .irq(irq)
	);

	ats_ctrl_model u_ctrl
	(
		.pclk(pclk), .go(go), .corrupt(corrupt), .ready_in(rdy_pin), .bit0_in(d0),
		.bit1_in(d1), .home_mode_in(home_mode_in), .home_start_in(home_start_in),
		.deviation_clear_out(dev_clr), .motion_ok(motion_ok),
		.mode_out(mode), .request_out(req), .torque_status(torque_status),
		.word_out(word_out), .sum_ok(sum_ok), .xfer_done(xfer_done),
		.comm_error_flag(comm_error_flag), .checksum_error_flag(checksum_error_flag)
	);

	always #5 pclk = ~pclk;

	task report_and_stop;
		if (failures == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task check(input logic [32:0] seen, input logic [32:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// APB master; one idle edge after each transfer avoids double drives
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task rd(input logic [7:0] a, input logic [32:0] exp);
		q_apb.push_back(exp);
		apb(1'b0, a, 32'h0);
	endtask

	task wait_end;
		t = 0;
		while (xfer_done !== 1'b1 && comm_error_flag !== 1'b1 && t < 3000)
		begin
			@(posedge pclk);
			t++;
		end
		if (t >= 3000)
			failures++;
		@(posedge pclk);
	endtask

	task run_xfer(input logic [32:0] exp);
		q_x.push_back(exp);
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		wait_end;
	endtask

	// Result watchers take the oldest expectation as each answer appears
	always @(posedge pclk)
	begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			check({pslverr, prdata}, q_apb.pop_front());
		if (xfer_done === 1'b1)
			check({sum_ok, word_out}, q_x.pop_front());
		if (mode === 1'b1)
			check({32'h0, dev_clr}, 33'h0);
		mode_q <= mode;
		if (mode && !mode_q)
			attempts <= attempts + 32'h1;
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			failures++;
			report_and_stop;
		end
	end

	initial
	begin
		void'($urandom(63));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Power-up leaves a transfer pending; unmapped read is refused
		rd(`ATS_STATUS_OFS, 33'h008);
		rd(`ATS_INT_STAT_OFS, 33'h001);
		rd(`ATS_CTRL_OFS, 33'h0);
		rd(`ATS_INT_MASK_OFS, 33'h0);
		rd(8'h40, 33'h100000000);
		check({32'h0, motion_ok}, 33'h0);
		// Shared pins carry status outside a transfer
		for (i = 0; i < 8; i++)
		begin
			v = $urandom;
			torque_limiting_in <= v[0];
			in_position_in <= v[1];
			zero_speed_in <= v[2];
			@(posedge pclk);
			@(posedge pclk);
			check({32'h0, rdy_pin}, {32'h0, v[0]});
			check({31'h0, d1, d0}, {31'h0, v[2:1]});
			check({32'h0, torque_status}, {32'h0, v[0]});
		end
		torque_limiting_in <= 1'b0;
		// Brake output only for the interlock selection
		for (i = 3; i >= 0; i--)
		begin
			apb(1'b1, `ATS_CTRL_OFS, i);
			@(posedge pclk);
			check({32'h0, brake}, {32'h0, i == 1});
		end
		apb(1'b1, `ATS_CTRL_OFS, 32'h1);
		// Alarm reset and emergency release both re-arm a transfer
		for (i = 0; i < 2; i++)
		begin
			apb(1'b1, `ATS_INT_STAT_OFS, 32'hf);
			alarm_reset_in <= (i == 0);
			emg_stop_in <= (i == 1);
			@(posedge pclk);
			alarm_reset_in <= 1'b0;
			emg_stop_in <= 1'b0;
			@(posedge pclk);
			@(posedge pclk);
			rd(`ATS_INT_STAT_OFS, 33'h001);
		end
		// Interrupt follows only unmasked sticky bits
		apb(1'b1, `ATS_INT_MASK_OFS, 32'h2);
		check({32'h0, irq}, 33'h0);
		apb(1'b1, `ATS_INT_MASK_OFS, 32'h1);
		check({32'h0, irq}, 33'h1);
		apb(1'b1, `ATS_INT_STAT_OFS, 32'h1);
		check({32'h0, irq}, 33'h0);
		apb(1'b1, `ATS_INT_MASK_OFS, 32'h2);
		// Home start in home mode makes the present position the origin
		pos = $urandom;
		motor_position_in <= pos;
		home_mode_in <= 1'b1;
		@(posedge pclk);
		home_start_in <= 1'b1;
		@(posedge pclk);
		home_start_in <= 1'b0;
		home_mode_in <= 1'b0;
		@(posedge pclk);
		@(posedge pclk);
		check({32'h0, dev_clr}, 33'h1);
		rd(`ATS_HOME_OFS_OFS, {1'b0, pos});
		rd(`ATS_POSITION_OFS, 33'h0);
		rd(`ATS_INT_STAT_OFS, 33'h008);
		apb(1'b1, `ATS_INT_STAT_OFS, 32'hf);
		// Clear pulse stands its full length, then ends before any transfer
		repeat (780) @(posedge pclk);
		check({32'h0, dev_clr}, 33'h1);
		repeat (10) @(posedge pclk);
		check({32'h0, dev_clr}, 33'h0);
		// Transfers of boundary and random offsets; motor held still
		for (i = 0; i < 3; i++)
		begin
			v = (i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : $urandom;
			motor_position_in <= pos + v;
			@(posedge pclk);
			run_xfer({1'b1, v});
			check({32'h0, irq}, 33'h1);
		end
		rd(`ATS_STATUS_OFS, 33'h020);
		check({32'h0, motion_ok}, 33'h1);
		// Noise on every attempt exhausts the retries
		corrupt <= 1'b1;
		a0 = attempts;
		run_xfer({1'b0, v ^ 32'h1});
		check({1'b0, attempts - a0}, 33'h4);
		check({32'h0, checksum_error_flag}, 33'h1);
		check({32'h0, motion_ok}, 33'h0);
		corrupt <= 1'b0;
		// Alarm mid-transfer aborts; the stalled handshake times out
		apb(1'b1, `ATS_INT_STAT_OFS, 32'hf);
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		repeat (30) @(posedge pclk);
		alarm_in <= 1'b1;
		wait_end;
		check({32'h0, comm_error_flag}, 33'h1);
		check({32'h0, brake}, 33'h0);
		rd(`ATS_INT_STAT_OFS, 33'h004);
		// Every noted expectation must have met its answer
		check(q_apb.size() + q_x.size(), 33'h0);
		report_and_stop;
	end
endmodule // test_abs_transfer_supervisor
